/* tb/pcmh_bench.sv */
// bench: codec port and highway controller joined over the link
`timescale 1ns/1ps
module pcmh_bench;
   typedef struct packed {
      logic [7:0]  cr0;
      logic [7:0]  ctrl;
      logic [13:0] s1;
      logic [13:0] s2;
      logic [27:0] exp;
   } pcmh_case_t;

   // codec config, controller config, samples, expected slot bits
   localparam pcmh_case_t CASES [7] = '{
      '{8'h03, 8'h13, 14'h2000, 14'h1FC0, 28'h000807F},
      '{8'h05, 8'h13, 14'h0A80, 14'h3FC0, 28'h0002AD5},
      '{8'h22, 8'h13, 14'h1234, 14'h0000, 28'h000FF00},
      '{8'h14, 8'h17, 14'h2000, 14'h2000, 28'h000D5D5},
      '{8'h0B, 8'h1B, 14'h1FFF, 14'h2000, {14'h1FFF, 14'h2000}},
      '{8'h1D, 8'h1F, 14'h3FFF, 14'h1555, {14'h3FFF, 14'h0000}},
      '{8'h08, 8'h1B, 14'h0155, 14'h2AAA, 28'h0000000}
   };
   localparam logic [3:0] REGS [5] = '{pcmh_pkg::REG_CODEC0,
      pcmh_pkg::REG_SLIC1, pcmh_pkg::REG_OUT1, pcmh_pkg::REG_SLIC2,
      pcmh_pkg::REG_OUT2};

   logic        clk_i, rst_n_i, cyc, stb, we, ack, dwr;
   logic [7:0]  adr, dwdata, drdata;
   logic [31:0] wdat, rdat, rd;
   logic [3:0]  daddr;
   logic [13:0] s1, s2, r1, r2;
   logic [1:0]  pos_en, neg_en, tone_en, opa_en;
   logic        sg_en, ag, rate, tk, rv;
   logic [2:0]  m1, m2;
   int          num_errors, num_checks, cycles, pulses;

   pcmh_link_if link ();

   // small frame keeps the run short
   pcmh_ctl #(.FRAME_CYCLES(320)) pcmh_ctl_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

   pcmh_dev pcmh_dev_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
      .reg_wr_i(dwr), .reg_addr_i(daddr), .reg_wdata_i(dwdata),
      .reg_rdata_o(drdata), .ch1_tx_sample_i(s1), .ch2_tx_sample_i(s2),
      .tx_sample_taken_o(tk), .ch1_rx_sample_o(r1), .ch2_rx_sample_o(r2),
      .rx_sample_valid_o(rv), .rx_analog_out_pos_en_o(pos_en),
      .rx_analog_out_neg_en_o(neg_en), .tone_analog_out_en_o(tone_en),
      .tx_opamp_out_en_o(opa_en), .system_ground_ref_out_en_o(sg_en),
      .internal_ground_ref_node_at_ag_o(ag), .slic1_mode_o(m1),
      .slic2_mode_o(m2), .master_clock_rate_select_o(rate));

   pcmh_link_chk pcmh_link_chk_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .bit_shift_clock(link.bit_shift_clock),
      .rx_frame_sync(link.rx_frame_sync),
      .tx_frame_sync(link.tx_frame_sync),
      .serial_rx_line(link.serial_rx_line),
      .serial_tx_line_do(link.serial_tx_line_do),
      .serial_tx_line_oe(link.serial_tx_line_oe),
      .serial_tx_line(link.serial_tx_line),
      .tx_valid_strobe_n(link.tx_valid_strobe_n),
      .power_down_n(link.power_down_n));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   // taken and valid pulses, one of each per frame
   always @(posedge clk_i) pulses += tk + rv;

   // a hung handshake or missing frame ends up here
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic dw(input logic [3:0] a, input logic [7:0] d);
      dwr <= 1'b1;
      daddr <= a;
      dwdata <= d;
      @(posedge clk_i);
      dwr <= 1'b0;
      @(posedge clk_i);
   endtask : dw

   task automatic dr(input logic [3:0] a, input logic [7:0] e);
      daddr <= a;
      repeat (2) @(posedge clk_i);
      chk(drdata, e);
   endtask : dr

   task automatic reset_values();
      wb(1'b0, pcmh_pkg::WB_CTRL, 32'h0);
      chk(rd, {24'h0, pcmh_pkg::CTRL_RESET});
      wb(1'b0, pcmh_pkg::WB_FRAME, 32'h0);
      chk(rd, 32'h28);
      wb(1'b1, 8'h18, 32'hFFFF_FFFF);
      wb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0);
      foreach (REGS[i]) dr(REGS[i], pcmh_pkg::CR_RESET);
      dw(4'h3, 8'hFF);
      dr(4'h3, 8'h00);
   endtask : reset_values

   // diff select on channel 1 only, every power-save combination
   task automatic enables();
      dw(pcmh_pkg::REG_OUT1, 8'h80);
      for (int m = 0; m < 4; m++) begin
         dw(pcmh_pkg::REG_CODEC0, 8'(m));
         @(posedge clk_i);
         chk(opa_en, m[1:0]);
         chk(pos_en, m[1:0]);
         chk(neg_en, m[1:0] & 2'h1);
         chk(tone_en, m[1:0]);
         chk({sg_en, ag}, {m != 0, m == 0});
      end
   endtask : enables

   // power down lands in mid frame with both channels on
   task automatic power_down_case();
      @(negedge link.tx_valid_strobe_n);
      wb(1'b1, pcmh_pkg::WB_CTRL, 32'h12);
      repeat (4) @(posedge clk_i);
      chk(link.tx_valid_strobe_n, 1'b1);
      chk(link.serial_tx_line, 1'b1);
      chk({pos_en, neg_en, tone_en, opa_en, sg_en, ag}, 10'h001);
      dw(pcmh_pkg::REG_SLIC1, 8'hA0);
      dw(pcmh_pkg::REG_SLIC2, 8'h60);
      dr(pcmh_pkg::REG_SLIC1, 8'hA0);
      chk({m1, m2}, 6'h2B);
      wb(1'b1, pcmh_pkg::WB_CTRL, 32'h11);
      repeat (4) @(posedge clk_i);
      dr(pcmh_pkg::REG_SLIC2, 8'h00);
      chk({m1, m2}, 6'h00);
      wb(1'b1, pcmh_pkg::WB_CTRL, 32'h13);
   endtask : power_down_case

   // reconfigure in the gap, then collect one frame as the far end sees it
   task automatic run_case(input pcmh_case_t c);
      logic [27:0] got;
      int          nb;
      int          p0;
      got = '0;
      nb = c.cr0[3] ? 28 : 16;
      @(posedge link.tx_valid_strobe_n);
      dw(pcmh_pkg::REG_CODEC0, c.cr0);
      wb(1'b1, pcmh_pkg::WB_CTRL, {24'h0, c.ctrl});
      s1 <= c.s1;
      s2 <= c.s2;
      @(negedge link.tx_valid_strobe_n);
      p0 = pulses;
      repeat (nb) begin
         @(posedge link.bit_shift_clock);
         got = {got[26:0], link.serial_tx_line};
      end
      chk(link.tx_valid_strobe_n, 1'b0);
      chk(got, c.exp);
      repeat (8) @(posedge clk_i);
      chk(link.tx_valid_strobe_n, 1'b1);
      chk(rate, c.cr0[5]);
      chk(pulses - p0, 2);
      if (c.cr0[3]) begin
         chk(r1, 14'h2ABC);
         chk(r2, 14'h1357);
      end else begin
         chk(r1, 14'h2A80);
         chk(r2, 14'h1340);
      end
   endtask : run_case

   initial begin
      rst_n_i = 1'b0;
      {cyc, stb, we, dwr} = 4'h0;
      adr = 8'h00;
      wdat = 32'h0;
      daddr = 4'h0;
      dwdata = 8'h00;
      s1 = 14'h0000;
      s2 = 14'h0000;
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      reset_values();
      wb(1'b1, pcmh_pkg::WB_TXD, 32'h1357_2ABC);
      wb(1'b1, pcmh_pkg::WB_CTRL, 32'h13);
      enables();
      power_down_case();
      foreach (CASES[i]) run_case(CASES[i]);
      conclude();
   end
endmodule : pcmh_bench

/* tb/pcmh_link_chk.sv */
// concurrent checks on the highway wires between controller and codec port
`timescale 1ns/1ps
module pcmh_link_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic bit_shift_clock,
   input wire logic rx_frame_sync,
   input wire logic tx_frame_sync,
   input wire logic serial_rx_line,
   input wire logic serial_tx_line_do,
   input wire logic serial_tx_line_oe,
   input wire logic serial_tx_line,
   input wire logic tx_valid_strobe_n,
   input wire logic power_down_n
);
   logic       sync_d_r;
   logic [3:0] since_sync_r;

   // cycles since the last sync edge, saturating
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_d_r     <= 1'b0;
         since_sync_r <= 4'hF;
      end else begin
         sync_d_r <= tx_frame_sync;
         if (tx_frame_sync != sync_d_r) begin
            since_sync_r <= 4'h0;
         end else if (since_sync_r != 4'hF) begin
            since_sync_r <= since_sync_r + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // synchroniser delay plus output register
   sequence s_pdn_held;
      !power_down_n [*5];
   endsequence
   sequence s_bit_rise;
      power_down_n [*4] ##0 $rose(bit_shift_clock);
   endsequence

   property p_open_drain;
      serial_tx_line_oe |-> !serial_tx_line_do && !serial_tx_line;
   endproperty
   property p_float_pdn;
      s_pdn_held |-> !serial_tx_line_oe && tx_valid_strobe_n;
   endproperty
   property p_drive_in_frame;
      serial_tx_line_oe |-> !tx_valid_strobe_n;
   endproperty
   property p_frame_after_sync;
      $fell(tx_valid_strobe_n) |-> since_sync_r inside {[4'h1:4'h6]};
   endproperty
   property p_bit_stable;
      s_bit_rise |-> $stable(serial_tx_line_oe);
   endproperty
   property p_sync_pair;
      rx_frame_sync == tx_frame_sync;
   endproperty
   property p_bclk_half;
      $rose(bit_shift_clock) |-> bit_shift_clock [*4];
   endproperty
   property p_rx_launch;
      $changed(serial_rx_line) || $changed(tx_frame_sync)
         |-> $rose(bit_shift_clock);
   endproperty

   a_open_drain: assert property (p_open_drain)
      else $error("tx line not pulled low while enabled");
   a_float_pdn: assert property (p_float_pdn)
      else $error("tx line or strobe active in power down");
   a_drive_in_frame: assert property (p_drive_in_frame)
      else $error("tx line driven outside a frame");
   a_frame_after_sync: assert property (p_frame_after_sync)
      else $error("frame start not tied to a sync edge");
   a_bit_stable: assert property (p_bit_stable)
      else $error("tx bit changes at bit clock rise");
   a_sync_pair: assert property (p_sync_pair)
      else $error("receive and transmit syncs differ");
   a_bclk_half: assert property (p_bclk_half)
      else $error("bit clock high phase too short");
   a_rx_launch: assert property (p_rx_launch)
      else $error("rx data or sync moved off a bit clock rise");
endmodule : pcmh_link_chk

/* verilog/pcmh_ctl.sv */
// highway controller: makes bit clock and syncs, wishbone registers
`timescale 1ns/1ps
module pcmh_ctl #(
   parameter int FRAME_CYCLES = pcmh_pkg::FRAME_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   pcmh_link_if.ctl         link,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic [7:0]  ctrl;
      logic [7:0]  half;
      logic [15:0] frame_bits;
      logic [13:0] txd1;
      logic [13:0] txd2;
      logic [13:0] rxd1;
      logic [13:0] rxd2;
      logic        done;
      logic        seen;
      logic [7:0]  div_cnt;
      logic        bclk;
      logic [15:0] bit_idx;
      logic        sync;
      logic        dout;
      logic [27:0] tx_sh;
      logic [27:0] rx_sh;
      logic        txl_s1;
      logic        txl_s2;
      logic        stb_s1;
      logic        stb_s2;
   } pcmh_ctl_st_t;

   localparam pcmh_ctl_st_t RST = '{
      ctrl: pcmh_pkg::CTRL_RESET,
      half: 8'(pcmh_pkg::BCLK_HALF_DEF),
      frame_bits: 16'(FRAME_CYCLES / (2 * pcmh_pkg::BCLK_HALF_DEF)),
      default: '0};

   pcmh_ctl_st_t s;
   pcmh_ctl_st_t n;

   function automatic logic [31:0] rd_val(input pcmh_ctl_st_t v,
                                          input logic [7:0] a);
      if (a == pcmh_pkg::WB_CTRL) return {24'h000000, v.ctrl};
      else if (a == pcmh_pkg::WB_DIV) return {24'h000000, v.half};
      else if (a == pcmh_pkg::WB_TXD) return {2'h0, v.txd2, 2'h0, v.txd1};
      else if (a == pcmh_pkg::WB_RXD) return {2'h0, v.rxd2, 2'h0, v.rxd1};
      else if (a == pcmh_pkg::WB_STAT) return {30'h00000000, v.seen, v.done};
      else if (a == pcmh_pkg::WB_FRAME) return {16'h0000, v.frame_bits};
      else return 32'h00000000;
   endfunction : rd_val

   logic [31:0] mrg;
   logic [31:0] cur;
   logic        wr;
   logic        rise;
   logic [15:0] nb;
   logic [15:0] total;
   logic        lin;

   always_comb begin
      n = s;
      lin = s.ctrl[pcmh_pkg::C_LIN];
      total = {11'h000, lin ? pcmh_pkg::BITS_14 : pcmh_pkg::BITS_8};
      // wishbone: answer one cycle after the request, write at ack edge
      n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
      cur = rd_val(s, wb_adr_i);
      if (wb_cyc_i && wb_stb_i && !s.ack) begin
         n.dat = cur;
      end
      wr = s.ack & wb_cyc_i & wb_stb_i & wb_we_i;
      for (int i = 0; i < 4; i++) begin
         mrg[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : cur[i*8 +: 8];
      end
      if (wr) begin
         if (wb_adr_i == pcmh_pkg::WB_CTRL) begin
            n.ctrl = mrg[7:0];
         end else if (wb_adr_i == pcmh_pkg::WB_DIV) begin
            n.half = mrg[7:0];
         end else if (wb_adr_i == pcmh_pkg::WB_TXD) begin
            n.txd1 = mrg[13:0];
            n.txd2 = mrg[29:16];
         end else if (wb_adr_i == pcmh_pkg::WB_STAT) begin
            n.done = s.done & ~mrg[0];
            n.seen = s.seen & ~mrg[1];
         end else if (wb_adr_i == pcmh_pkg::WB_FRAME) begin
            n.frame_bits = mrg[15:0];
         end
      end
      // link side samples
      n.txl_s1 = link.serial_tx_line;
      n.txl_s2 = s.txl_s1;
      n.stb_s1 = link.tx_valid_strobe_n;
      n.stb_s2 = s.stb_s1;
      if (!s.stb_s2) begin
         n.seen = 1'b1;
      end
      // bit clock divided from own clock
      rise = 1'b0;
      nb = (s.bit_idx == s.frame_bits - 16'h0001) ? 16'h0000
                                                  : s.bit_idx + 16'h0001;
      if (!s.ctrl[pcmh_pkg::C_RUN]) begin
         n.div_cnt = 8'h00;
         n.bclk = 1'b0;
         n.sync = 1'b0;
         n.dout = 1'b0;
         n.bit_idx = s.frame_bits - 16'h0001;
      end else if (s.div_cnt == s.half - 8'h01) begin
         n.div_cnt = 8'h00;
         n.bclk = ~s.bclk;
         rise = ~s.bclk;
      end else begin
         n.div_cnt = s.div_cnt + 8'h01;
      end
      if (rise) begin
         n.bit_idx = nb;
         // sync edge aligned with the bit clock rise
         n.sync = s.ctrl[pcmh_pkg::C_SHORT] ? (nb == s.frame_bits - 16'h0001)
                                            : (nb < pcmh_pkg::LONG_SYNC_BITS);
         if (nb == 16'h0000) begin
            n.tx_sh = lin ? {s.txd1, s.txd2}
                          : {s.txd1[13:6], s.txd2[13:6], 12'h000};
         end else begin
            n.tx_sh = {s.tx_sh[26:0], 1'b0};
         end
         n.dout = (nb < total) ? n.tx_sh[27] : 1'b0;
         // previous bit sampled here, so the full bit period must cover sync lag
         if (nb != 16'h0000 && nb <= total) begin
            n.rx_sh = {s.rx_sh[26:0], s.txl_s2};
            if (nb == total) begin
               n.rxd1 = lin ? n.rx_sh[27:14] : {n.rx_sh[15:8], 6'h00};
               n.rxd2 = lin ? n.rx_sh[13:0] : {n.rx_sh[7:0], 6'h00};
               n.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.dat;
   assign link.bit_shift_clock = s.bclk;
   assign link.rx_frame_sync = s.sync;
   assign link.tx_frame_sync = s.sync;
   assign link.serial_rx_line = s.dout;
   assign link.power_down_n = s.ctrl[pcmh_pkg::C_PDN];
   assign link.register_reset_n = s.ctrl[pcmh_pkg::C_RRST];
endmodule : pcmh_ctl

/* verilog/pcmh_dev.sv */
// codec pcm highway port: serial slots, idle codes, output enables
`timescale 1ns/1ps
module pcmh_dev (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   pcmh_link_if.dev         link,
   input  wire logic        reg_wr_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic [7:0]       reg_rdata_o,
   input  wire logic [13:0] ch1_tx_sample_i,
   input  wire logic [13:0] ch2_tx_sample_i,
   output logic             tx_sample_taken_o,
   output logic [13:0]      ch1_rx_sample_o,
   output logic [13:0]      ch2_rx_sample_o,
   output logic             rx_sample_valid_o,
   output logic [1:0]       rx_analog_out_pos_en_o,
   output logic [1:0]       rx_analog_out_neg_en_o,
   output logic [1:0]       tone_analog_out_en_o,
   output logic [1:0]       tx_opamp_out_en_o,
   output logic             system_ground_ref_out_en_o,
   output logic             internal_ground_ref_node_at_ag_o,
   output logic [2:0]       slic1_mode_o,
   output logic [2:0]       slic2_mode_o,
   output logic             master_clock_rate_select_o
);
   typedef struct packed {
      logic        bclk_s1;
      logic        bclk_s2;
      logic        bclk_d;
      logic        rs_s1;
      logic        rs_s2;
      logic        rs_d;
      logic        xs_s1;
      logic        xs_s2;
      logic        xs_d;
      logic        rxd_s1;
      logic        rxd_s2;
      logic        pd_s1;
      logic        pd_s2;
      logic        rr_s1;
      logic        rr_s2;
      logic [7:0]  cr0;
      logic [7:0]  slic1;
      logic [7:0]  slic2;
      logic [7:0]  out1;
      logic [7:0]  out2;
      logic [7:0]  rdata;
      logic [27:0] tx_sh;
      logic [4:0]  tx_cnt;
      logic        tx_act;
      logic        tx_oe;
      logic        strb_n;
      logic        tx_take;
      logic [27:0] rx_sh;
      logic [4:0]  rx_cnt;
      logic        rx_act;
      logic [13:0] rx1;
      logic [13:0] rx2;
      logic        rx_vld;
   } pcmh_dev_st_t;

   localparam pcmh_dev_st_t RST = '{strb_n: 1'b1, default: '0};

   pcmh_dev_st_t s;
   pcmh_dev_st_t n;

   // slot content of one channel
   function automatic logic [13:0] slot_word(input logic act,
                                             input logic lin,
                                             input logic companding_law_select,
                                             input logic [13:0] smp);
      if (act) begin
         return lin ? smp : {smp[13:6], 6'h00};
      end else if (lin) begin
         return pcmh_pkg::IDLE_LIN;
      end
      return {(companding_law_select ? pcmh_pkg::IDLE_A : pcmh_pkg::IDLE_MU), 6'h00};
   endfunction : slot_word

   logic        pd_n;
   logic        lin;
   logic        short_m;
   logic [4:0]  last;
   logic        b_rise;
   logic        b_fall;
   logic        rx_start;
   logic        tx_start;
   logic [1:0]  ch_on;
   logic [13:0] w1;
   logic [13:0] w2;

   always_comb begin
      n = s;
      // two flops on every pin before use
      n.bclk_s1 = link.bit_shift_clock;
      n.bclk_s2 = s.bclk_s1;
      n.bclk_d = s.bclk_s2;
      n.rs_s1 = link.rx_frame_sync;
      n.rs_s2 = s.rs_s1;
      n.rs_d = s.rs_s2;
      n.xs_s1 = link.tx_frame_sync;
      n.xs_s2 = s.xs_s1;
      n.xs_d = s.xs_s2;
      n.rxd_s1 = link.serial_rx_line;
      n.rxd_s2 = s.rxd_s1;
      n.pd_s1 = link.power_down_n;
      n.pd_s2 = s.pd_s1;
      n.rr_s1 = link.register_reset_n;
      n.rr_s2 = s.rr_s1;
      n.rx_vld = 1'b0;
      n.tx_take = 1'b0;

      pd_n = s.pd_s2;
      lin = s.cr0[pcmh_pkg::B_LIN];
      short_m = s.cr0[pcmh_pkg::B_SHORT];
      last = (lin ? pcmh_pkg::BITS_14 : pcmh_pkg::BITS_8) - 5'h01;
      b_rise = s.bclk_s2 & ~s.bclk_d;
      b_fall = ~s.bclk_s2 & s.bclk_d;
      rx_start = short_m ? (~s.rs_s2 & s.rs_d) : (s.rs_s2 & ~s.rs_d);
      tx_start = short_m ? (~s.xs_s2 & s.xs_d) : (s.xs_s2 & ~s.xs_d);
      ch_on = s.cr0[1:0];
      w1 = slot_word(ch_on[0], lin, s.cr0[pcmh_pkg::B_COMPANDING_LAW_SELECT], ch1_tx_sample_i);
      w2 = slot_word(ch_on[1], lin, s.cr0[pcmh_pkg::B_COMPANDING_LAW_SELECT], ch2_tx_sample_i);

      // registers stay writable in power down and at any rate bit
      if (!s.rr_s2) begin
         n.cr0 = pcmh_pkg::CR_RESET;
         n.slic1 = pcmh_pkg::CR_RESET;
         n.slic2 = pcmh_pkg::CR_RESET;
         n.out1 = pcmh_pkg::CR_RESET;
         n.out2 = pcmh_pkg::CR_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == pcmh_pkg::REG_CODEC0) begin
            n.cr0 = reg_wdata_i;
         end else if (reg_addr_i == pcmh_pkg::REG_SLIC1) begin
            n.slic1 = reg_wdata_i;
         end else if (reg_addr_i == pcmh_pkg::REG_OUT1) begin
            n.out1 = reg_wdata_i;
         end else if (reg_addr_i == pcmh_pkg::REG_SLIC2) begin
            n.slic2 = reg_wdata_i;
         end else if (reg_addr_i == pcmh_pkg::REG_OUT2) begin
            n.out2 = reg_wdata_i;
         end
      end
      if (reg_addr_i == pcmh_pkg::REG_CODEC0) begin
         n.rdata = s.cr0;
      end else if (reg_addr_i == pcmh_pkg::REG_SLIC1) begin
         n.rdata = s.slic1;
      end else if (reg_addr_i == pcmh_pkg::REG_OUT1) begin
         n.rdata = s.out1;
      end else if (reg_addr_i == pcmh_pkg::REG_SLIC2) begin
         n.rdata = s.slic2;
      end else if (reg_addr_i == pcmh_pkg::REG_OUT2) begin
         n.rdata = s.out2;
      end else begin
         n.rdata = 8'h00;
      end

      // transmit: sync edge launches bit 0, later rises shift
      if (tx_start) begin
         n.tx_act = 1'b1;
         n.tx_cnt = 5'h00;
         n.tx_take = 1'b1;
         n.tx_sh = lin ? {w1, w2} : {w1[13:6], w2[13:6], 12'h000};
      end else if (b_rise && s.tx_act) begin
         if (s.tx_cnt == last) begin
            n.tx_act = 1'b0;
         end else begin
            n.tx_sh = {s.tx_sh[26:0], 1'b0};
            n.tx_cnt = s.tx_cnt + 5'h01;
         end
      end

      // receive: sample on falls after the sync edge
      if (rx_start) begin
         n.rx_act = 1'b1;
         n.rx_cnt = 5'h00;
      end else if (b_fall && s.rx_act) begin
         n.rx_sh = {s.rx_sh[26:0], s.rxd_s2};
         n.rx_cnt = s.rx_cnt + 5'h01;
         if (s.rx_cnt == last) begin
            n.rx_act = 1'b0;
            n.rx_vld = 1'b1;
            n.rx1 = lin ? n.rx_sh[27:14] : {n.rx_sh[15:8], 6'h00};
            n.rx2 = lin ? n.rx_sh[13:0] : {n.rx_sh[7:0], 6'h00};
         end
      end

      // power down aborts both directions whatever the channel bits
      if (!pd_n) begin
         n.tx_act = 1'b0;
         n.rx_act = 1'b0;
         n.tx_take = 1'b0;
      end
      n.tx_oe = n.tx_act & ~n.tx_sh[27];
      n.strb_n = ~n.tx_act;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   // analog enables per channel
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic on;
      logic diff;
      assign on = s.pd_s2 & s.cr0[c];
      assign diff = (c == 0) ? s.out1[pcmh_pkg::B_DIFF]
                             : s.out2[pcmh_pkg::B_DIFF];
      assign rx_analog_out_pos_en_o[c] = on;
      assign rx_analog_out_neg_en_o[c] = on & diff;
      assign tone_analog_out_en_o[c] = on;
      assign tx_opamp_out_en_o[c] = on;
   end

   assign system_ground_ref_out_en_o = s.pd_s2 & (|s.cr0[1:0]);
   assign internal_ground_ref_node_at_ag_o = ~(s.pd_s2 & (|s.cr0[1:0]));
   assign slic1_mode_o = s.slic1[pcmh_pkg::B_SLIC_LO +: 3];
   assign slic2_mode_o = s.slic2[pcmh_pkg::B_SLIC_LO +: 3];
   assign master_clock_rate_select_o = s.cr0[pcmh_pkg::B_MCLK_SEL];
   assign reg_rdata_o = s.rdata;
   assign tx_sample_taken_o = s.tx_take;
   assign ch1_rx_sample_o = s.rx1;
   assign ch2_rx_sample_o = s.rx2;
   assign rx_sample_valid_o = s.rx_vld;
   assign link.serial_tx_line_do = 1'b0;
   assign link.serial_tx_line_oe = s.tx_oe;
   assign link.tx_valid_strobe_n = s.strb_n;
endmodule : pcmh_dev

/* verilog/pcmh_link_if.sv */
// pcm highway wires between the codec port and its controller
`timescale 1ns/1ps
interface pcmh_link_if;
   logic bit_shift_clock;
   logic rx_frame_sync;
   logic tx_frame_sync;
   logic serial_rx_line;
   logic serial_tx_line_do;
   logic serial_tx_line_oe;
   logic serial_tx_line;
   logic tx_valid_strobe_n;
   logic power_down_n;
   logic register_reset_n;

   // open drain with board pull-up
   assign serial_tx_line = serial_tx_line_oe ? serial_tx_line_do
                                             : 1'b1;

   modport dev (
      input  bit_shift_clock, rx_frame_sync, tx_frame_sync, serial_rx_line,
      input  power_down_n, register_reset_n,
      output serial_tx_line_do, serial_tx_line_oe, tx_valid_strobe_n
   );
   modport ctl (
      output bit_shift_clock, rx_frame_sync, tx_frame_sync, serial_rx_line,
      output power_down_n, register_reset_n,
      input  serial_tx_line, tx_valid_strobe_n
   );
endinterface : pcmh_link_if

/* verilog/pcmh_pkg.sv */
// shared constants for the pcm highway port and its controller
package pcmh_pkg;
   localparam int CLK_HZ        = 100_000_000;
   localparam int FRAME_HZ      = 8000;
   localparam int FRAME_CYCLES  = CLK_HZ / FRAME_HZ;
   localparam int BCLK_HALF_DEF = 4;
   localparam int FRAME_BITS_DEF = FRAME_CYCLES / (2 * BCLK_HALF_DEF);
   // device control register indices
   localparam logic [3:0] REG_CODEC0 = 4'h0;
   localparam logic [3:0] REG_SLIC1  = 4'h6;
   localparam logic [3:0] REG_OUT1   = 4'h7;
   localparam logic [3:0] REG_SLIC2  = 4'hD;
   localparam logic [3:0] REG_OUT2   = 4'hE;
   localparam logic [7:0] CR_RESET   = 8'h00;
   // codec_control_reg_zero fields, then the output register diff bit and the slic register mode field
   localparam int B_MCLK_SEL = 5;
   localparam int B_SHORT    = 4;
   localparam int B_LIN      = 3;
   localparam int B_COMPANDING_LAW_SELECT     = 2;
   localparam int B_DIFF     = 7;
   localparam int B_SLIC_LO  = 5;
   // slot codes and frame sizes
   localparam logic [7:0]  IDLE_MU   = 8'hFF;
   localparam logic [7:0]  IDLE_A    = 8'hD5;
   localparam logic [13:0] IDLE_LIN  = 14'h0000;
   localparam logic [4:0]  BITS_8    = 5'h10;
   localparam logic [4:0]  BITS_14   = 5'h1C;
   // controller register map (byte addresses)
   localparam logic [7:0] WB_CTRL  = 8'h00;
   localparam logic [7:0] WB_DIV   = 8'h04;
   localparam logic [7:0] WB_TXD   = 8'h08;
   localparam logic [7:0] WB_RXD   = 8'h0C;
   localparam logic [7:0] WB_STAT  = 8'h10;
   localparam logic [7:0] WB_FRAME = 8'h14;
   localparam int C_PDN   = 0;
   localparam int C_RRST  = 1;
   localparam int C_SHORT = 2;
   localparam int C_LIN   = 3;
   localparam int C_RUN   = 4;
   localparam logic [7:0]  CTRL_RESET     = 8'h03;
   localparam logic [15:0] LONG_SYNC_BITS = 16'h0008;
endpackage : pcmh_pkg
